// ==== cmo_pkg.sv ====
package cmo_pkg;

   // ------------------------------------------------------------
   // object geometry
   // ------------------------------------------------------------
   localparam int NUM_OBJ    = 6;
   localparam int OBJ_W      = 3;
   localparam int MAX_LEN    = 8;
   localparam logic [3:0] LEN_CAP = 4'h8;
   localparam logic [3:0] OBJ_LIMIT = 4'h6;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_PAGE     = 8'h00;
   localparam logic [7:0] OFF_CTRL     = 8'h04;
   localparam logic [7:0] OFF_TAG4     = 8'h08;
   localparam logic [7:0] OFF_TAG3     = 8'h0C;
   localparam logic [7:0] OFF_TAG2     = 8'h10;
   localparam logic [7:0] OFF_TAG1     = 8'h14;
   localparam logic [7:0] OFF_MASK4    = 8'h18;
   localparam logic [7:0] OFF_MASK3    = 8'h1C;
   localparam logic [7:0] OFF_MASK2    = 8'h20;
   localparam logic [7:0] OFF_MASK1    = 8'h24;
   localparam logic [7:0] OFF_STAMP_LO = 8'h28;
   localparam logic [7:0] OFF_STAMP_HI = 8'h2C;
   localparam logic [7:0] OFF_OBJ_STAT = 8'h30;
   localparam logic [7:0] OFF_ENABLE   = 8'h34;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h38;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h3C;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h40;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_CFG_HI = 7;
   localparam int CTRL_CFG_LO = 6;
   localparam int CTRL_RPLY   = 5;
   localparam int CTRL_EXT    = 4;
   localparam int PAGE_NUM_HI = 7;
   localparam int PAGE_NUM_LO = 4;
   localparam int ST_LENW     = 7;
   localparam int ST_TXDONE   = 6;
   localparam int ST_RXDONE   = 5;
   localparam int TAG_REMOTE  = 2;
   localparam int TAG_RESV1   = 1;
   localparam int TAG_RESV0   = 0;
   localparam int MSK_REMOTE  = 2;
   localparam int MSK_EXT     = 0;
   localparam int IRQ_TX      = 0;
   localparam int IRQ_RX      = 1;
   localparam int IRQ_LENW    = 2;
   localparam int IRQ_W       = 3;
   localparam logic [31:0] STD_ID_MASK = 32'hFFE0_0000;
   localparam logic [31:0] EXT_ID_MASK = 32'hFFFF_FFF8;

   typedef enum logic [1:0] {
      CFG_OFF,
      CFG_TX,
      CFG_RX,
      CFG_FBUF
   } cmo_cfg_t;

   typedef struct packed {
      logic [28:0] id;
      logic        remote;
      logic        ext;
      logic        resv1;
      logic        resv0;
      logic [3:0]  len;
   } cmo_frame_t;

endpackage

// ==== cmo_descriptor.sv ====
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
// Behaviour
// RULE1 - configuration stays after completion; object idles until software rewrites it
// RULE2 - configuration write sets object enable bit and permits completion flag clear
// RULE3 - remote frame answered automatically only when reply-valid bit is one
// RULE4 - extension bit picks 11- or 29-bit format; reception loads it
// RULE5 - length values above eight are sent as eight
// RULE6 - reception loads length; mismatch raises length warning flag
// RULE7 - standard identifier in tag bits 31:21, sent and reloaded
// RULE8 - standard tag bits 20:3 and 1 ignored in compare, loaded on reception
// RULE9 - extended identifier in tag bits 31:3, sent and reloaded
// RULE10 - tag bit 2 is remote request; cleared before automatic reply
// RULE11 - reserved tag bits 0 and 1 sent and refreshed on reception; the code sends bit 1 only in extended frames
// RULE12 - identifier mask bit zero forces match, one enables compare
// RULE13 - mask bit 2 gates remote compare, mask bit 0 gates extension compare
// RULE14 - software writes reserved mask bits as zero
// RULE15 - read-only 16-bit stamp in low and high byte registers
// RULE16 - configuration codes: off, transmit, receive, frame-buffer receive
// RULE17 - page selector picks active object, numbers 0 to 5
// RULE18 - frame accepted only when every enabled masked bit matches the tag
module cmo_descriptor (
   input  wire logic               CLK,
   input  wire logic               RST_N,
   input  wire logic               HSEL,
   input  wire logic [31:0]        HADDR,
   input  wire logic [1:0]         HTRANS,
   input  wire logic               HWRITE,
   input  wire logic [2:0]         HSIZE,
   input  wire logic [31:0]        HWDATA,
   input  wire logic               HREADY,
   output logic                    HREADYOUT,
   output logic [31:0]             HRDATA,
   output logic                    HRESP,
   input  wire logic               RX_VALID,
   input  wire cmo_pkg::cmo_frame_t RX_FRAME,
   input  wire logic [15:0]        STAMP_NOW,
   output logic                    TX_REQ,
   output cmo_pkg::cmo_frame_t     TX_FRAME,
   input  wire logic               TX_DONE,
   output logic                    IRQ
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   localparam int OBJ_W = cmo_pkg::OBJ_W;

   cmo_pkg::cmo_cfg_t    cfg_q   [cmo_pkg::NUM_OBJ];
   logic                 rply_q  [cmo_pkg::NUM_OBJ];
   logic                 ext_q   [cmo_pkg::NUM_OBJ];
   logic [3:0]           len_q   [cmo_pkg::NUM_OBJ];
   logic [31:0]          tag_q   [cmo_pkg::NUM_OBJ];
   logic [31:0]          mask_q  [cmo_pkg::NUM_OBJ];
   logic [15:0]          stamp_q [cmo_pkg::NUM_OBJ];
   logic [cmo_pkg::NUM_OBJ-1:0] armed_q;
   logic [cmo_pkg::NUM_OBJ-1:0] lenw_q;
   logic [cmo_pkg::NUM_OBJ-1:0] txok_q;
   logic [cmo_pkg::NUM_OBJ-1:0] rxok_q;
   logic [7:0]           page_q;
   logic [cmo_pkg::IRQ_W-1:0] irq_stat_q;
   logic [cmo_pkg::IRQ_W-1:0] irq_en_q;

   logic [7:0]           addr_q;
   logic                 wr_q;
   logic                 rd_q;
   logic                 rd_wait_q;
   logic [31:0]          hrdata_q;
   logic                 tx_req_q;
   logic [cmo_pkg::OBJ_W-1:0] tx_obj_q;
   cmo_pkg::cmo_frame_t  tx_frame_q;

   logic                 take;
   logic                 page_ok;
   logic [cmo_pkg::OBJ_W-1:0] sel;
   logic                 wr_ok;
   logic [7:0]           wbyte;
   logic [31:0]          rd_d;
   logic                 hit;
   logic [cmo_pkg::OBJ_W-1:0] hit_obj;
   logic                 auto_reply;
   logic                 tx_any;
   logic [cmo_pkg::OBJ_W-1:0] tx_obj_d;
   cmo_pkg::cmo_frame_t  tx_frame_d;
   logic [31:0]          rx_tag;

   // ------------------------------------------------------------
   // AHB-Lite slave: writes have no wait, reads one wait state
   // ------------------------------------------------------------
   assign take      = HSEL && HTRANS[1] && HREADY;
   assign HREADYOUT = !rd_q || rd_wait_q;
   assign HRDATA    = hrdata_q;
   assign HRESP     = 1'b0;
   assign wr_ok     = wr_q;
   assign wbyte     = HWDATA[7:0];
   assign page_ok   = page_q[cmo_pkg::PAGE_NUM_HI:cmo_pkg::PAGE_NUM_LO] < cmo_pkg::OBJ_LIMIT; // RULE17
   assign sel       = page_q[cmo_pkg::PAGE_NUM_LO+cmo_pkg::OBJ_W-1:cmo_pkg::PAGE_NUM_LO];

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         addr_q    <= 8'h00;
         wr_q      <= 1'b0;
         rd_q      <= 1'b0;
         rd_wait_q <= 1'b0;
      end else begin
         if (HREADYOUT) begin
            addr_q <= HADDR[7:0];
            wr_q   <= take && HWRITE;
            rd_q   <= take && !HWRITE;
         end
         rd_wait_q <= rd_q && !rd_wait_q;
      end
   end

   // read data sampled in the wait cycle, so a preceding write is visible
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_q && !rd_wait_q) begin
         hrdata_q <= rd_d;
      end
   end

   always_comb begin
      rd_d = 32'h0000_0000;
      case (addr_q)
         cmo_pkg::OFF_PAGE:     rd_d[7:0] = page_q;
         cmo_pkg::OFF_ENABLE:   rd_d[cmo_pkg::NUM_OBJ-1:0] = armed_q;
         cmo_pkg::OFF_IRQ_STAT: rd_d[cmo_pkg::IRQ_W-1:0] = irq_stat_q;
         cmo_pkg::OFF_IRQ_EN:   rd_d[cmo_pkg::IRQ_W-1:0] = irq_en_q;
         default: rd_d = 32'h0000_0000;
      endcase
      if (page_ok) begin
         case (addr_q)
            cmo_pkg::OFF_CTRL:     rd_d[7:0] = {cfg_q[sel], rply_q[sel], ext_q[sel], len_q[sel]};
            cmo_pkg::OFF_TAG4:     rd_d[7:0] = tag_q[sel][7:0];
            cmo_pkg::OFF_TAG3:     rd_d[7:0] = tag_q[sel][15:8];
            cmo_pkg::OFF_TAG2:     rd_d[7:0] = tag_q[sel][23:16];
            cmo_pkg::OFF_TAG1:     rd_d[7:0] = tag_q[sel][31:24];
            cmo_pkg::OFF_MASK4:    rd_d[7:0] = mask_q[sel][7:0];
            cmo_pkg::OFF_MASK3:    rd_d[7:0] = mask_q[sel][15:8];
            cmo_pkg::OFF_MASK2:    rd_d[7:0] = mask_q[sel][23:16];
            cmo_pkg::OFF_MASK1:    rd_d[7:0] = mask_q[sel][31:24];
            cmo_pkg::OFF_STAMP_LO: rd_d[7:0] = stamp_q[sel][7:0];   // RULE15
            cmo_pkg::OFF_STAMP_HI: rd_d[7:0] = stamp_q[sel][15:8];  // RULE15
            cmo_pkg::OFF_OBJ_STAT: rd_d[7:5] = {lenw_q[sel], txok_q[sel], rxok_q[sel]};
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         page_q <= 8'h00;
      end else if (wr_ok && addr_q == cmo_pkg::OFF_PAGE) begin
         page_q <= wbyte;
      end
   end

   // ------------------------------------------------------------
   // acceptance filter, lowest object number wins
   // ------------------------------------------------------------
   assign rx_tag = RX_FRAME.ext ? {RX_FRAME.id, 3'b000} : {RX_FRAME.id[10:0], 21'h00000};

   always_comb begin
      logic [31:0] emask;
      logic        ok;
      emask   = 32'h0000_0000;
      ok      = 1'b0;
      hit     = 1'b0;
      hit_obj = '0;
      for (int i = cmo_pkg::NUM_OBJ - 1; i >= 0; i--) begin
         // reserved standard bits never take part in the compare
         emask = mask_q[i] & (ext_q[i] ? cmo_pkg::EXT_ID_MASK : cmo_pkg::STD_ID_MASK); // RULE8 RULE12
         ok = (((rx_tag ^ tag_q[i]) & emask) == 32'h0000_0000)                             // RULE18
            && (!mask_q[i][cmo_pkg::MSK_REMOTE]
                || RX_FRAME.remote == tag_q[i][cmo_pkg::TAG_REMOTE])                     // RULE13
            && (!mask_q[i][cmo_pkg::MSK_EXT] || RX_FRAME.ext == ext_q[i]);               // RULE13
         if (armed_q[i] && (cfg_q[i] == cmo_pkg::CFG_RX || cfg_q[i] == cmo_pkg::CFG_FBUF)
             && ok) begin                                                                // RULE16
            hit     = 1'b1;
            hit_obj = OBJ_W'(i);
         end
      end
   end

   // remote frame on a receiver with a ready reply turns it into a sender
   assign auto_reply = RX_VALID && hit && RX_FRAME.remote
                       && cfg_q[hit_obj] == cmo_pkg::CFG_RX && rply_q[hit_obj]; // RULE3

   // ------------------------------------------------------------
   // object fields: no reset value, as software must set them up
   // ------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RX_VALID && hit) begin
         ext_q[hit_obj]   <= RX_FRAME.ext;                              // RULE4
         len_q[hit_obj]   <= RX_FRAME.len;                              // RULE6
         stamp_q[hit_obj] <= STAMP_NOW;                                 // RULE15
         tag_q[hit_obj]   <= {rx_tag[31:3],
                              RX_FRAME.remote && !auto_reply,           // RULE10
                              RX_FRAME.resv1, RX_FRAME.resv0};          // RULE7 RULE9 RULE11
         if (auto_reply) begin
            cfg_q[hit_obj] <= cmo_pkg::CFG_TX;
         end
      end
      if (TX_DONE && tx_req_q) begin
         stamp_q[tx_obj_q] <= STAMP_NOW;
      end
      if (wr_ok && page_ok) begin
         case (addr_q)
            cmo_pkg::OFF_CTRL: begin
               cfg_q[sel]  <= cmo_pkg::cmo_cfg_t'(wbyte[cmo_pkg::CTRL_CFG_HI:cmo_pkg::CTRL_CFG_LO]);
               rply_q[sel] <= wbyte[cmo_pkg::CTRL_RPLY];
               ext_q[sel]  <= wbyte[cmo_pkg::CTRL_EXT];
               len_q[sel]  <= wbyte[3:0];
            end
            cmo_pkg::OFF_TAG4:  tag_q[sel][7:0]    <= wbyte;
            cmo_pkg::OFF_TAG3:  tag_q[sel][15:8]   <= wbyte;
            cmo_pkg::OFF_TAG2:  tag_q[sel][23:16]  <= wbyte;
            cmo_pkg::OFF_TAG1:  tag_q[sel][31:24]  <= wbyte;
            cmo_pkg::OFF_MASK4: mask_q[sel][7:0]   <= wbyte;
            cmo_pkg::OFF_MASK3: mask_q[sel][15:8]  <= wbyte;
            cmo_pkg::OFF_MASK2: mask_q[sel][23:16] <= wbyte;
            cmo_pkg::OFF_MASK1: mask_q[sel][31:24] <= wbyte;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // enable bits: cleared on completion, set by a config rewrite
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         armed_q <= '0;
      end else begin
         if (TX_DONE && tx_req_q) begin
            armed_q[tx_obj_q] <= 1'b0;                                  // RULE1
         end
         if (RX_VALID && hit && !auto_reply) begin
            armed_q[hit_obj] <= 1'b0;                                   // RULE1
         end
         if (wr_ok && page_ok && addr_q == cmo_pkg::OFF_CTRL) begin
            armed_q[sel] <= 1'b1;                                       // RULE2
         end
      end
   end

   // ------------------------------------------------------------
   // object status flags: hardware set beats software clear
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lenw_q <= '0;
         txok_q <= '0;
         rxok_q <= '0;
      end else begin
         if (wr_ok && page_ok && addr_q == cmo_pkg::OFF_OBJ_STAT) begin
            lenw_q[sel] <= wbyte[cmo_pkg::ST_LENW];
            // completion flags only clear once the object was rewritten
            if (armed_q[sel]) begin                                     // RULE2
               txok_q[sel] <= wbyte[cmo_pkg::ST_TXDONE];
               rxok_q[sel] <= wbyte[cmo_pkg::ST_RXDONE];
            end
         end
         if (TX_DONE && tx_req_q) begin
            txok_q[tx_obj_q] <= 1'b1;
         end
         if (RX_VALID && hit) begin
            if (RX_FRAME.len != len_q[hit_obj]) begin
               lenw_q[hit_obj] <= 1'b1;                                 // RULE6
            end
            if (!auto_reply) begin
               rxok_q[hit_obj] <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // transmit selection, lowest object number first
   // ------------------------------------------------------------
   always_comb begin
      logic [3:0] eff_len;
      eff_len    = 4'h0;
      tx_any     = 1'b0;
      tx_obj_d   = '0;
      tx_frame_d = '0;
      for (int i = cmo_pkg::NUM_OBJ - 1; i >= 0; i--) begin
         if (armed_q[i] && cfg_q[i] == cmo_pkg::CFG_TX) begin
            tx_any   = 1'b1;
            tx_obj_d = OBJ_W'(i);
         end
      end
      eff_len = (len_q[tx_obj_d] > cmo_pkg::LEN_CAP) ? cmo_pkg::LEN_CAP : len_q[tx_obj_d]; // RULE5
      tx_frame_d.id     = ext_q[tx_obj_d] ? tag_q[tx_obj_d][31:3]                         // RULE9
                                          : {18'h00000, tag_q[tx_obj_d][31:21]};          // RULE4 RULE7
      tx_frame_d.ext    = ext_q[tx_obj_d];                                                // RULE4
      tx_frame_d.remote = tag_q[tx_obj_d][cmo_pkg::TAG_REMOTE];                           // RULE10
      tx_frame_d.resv1  = ext_q[tx_obj_d] && tag_q[tx_obj_d][cmo_pkg::TAG_RESV1];         // RULE11
      tx_frame_d.resv0  = tag_q[tx_obj_d][cmo_pkg::TAG_RESV0];                            // RULE11
      tx_frame_d.len    = eff_len;
      if (!tx_any) begin
         tx_frame_d = '0;
      end
   end

   // request drops the cycle after completion so the same object is not resent
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tx_req_q   <= 1'b0;
         tx_obj_q   <= '0;
         tx_frame_q <= '0;
      end else begin
         tx_req_q   <= tx_any && !(TX_DONE && tx_req_q);
         tx_obj_q   <= tx_obj_d;
         tx_frame_q <= tx_frame_d;
      end
   end

   assign TX_REQ   = tx_req_q;
   assign TX_FRAME = tx_frame_q;

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else begin
         if (wr_ok && addr_q == cmo_pkg::OFF_IRQ_EN) begin
            irq_en_q <= HWDATA[cmo_pkg::IRQ_W-1:0];
         end
         if (wr_ok && addr_q == cmo_pkg::OFF_IRQ_CLR) begin
            irq_stat_q <= irq_stat_q & ~HWDATA[cmo_pkg::IRQ_W-1:0];
         end
         if (TX_DONE && tx_req_q) begin
            irq_stat_q[cmo_pkg::IRQ_TX] <= 1'b1;
         end
         if (RX_VALID && hit && !auto_reply) begin
            irq_stat_q[cmo_pkg::IRQ_RX] <= 1'b1;
         end
         if (RX_VALID && hit && RX_FRAME.len != len_q[hit_obj]) begin
            irq_stat_q[cmo_pkg::IRQ_LENW] <= 1'b1;
         end
      end
   end

   assign IRQ = |(irq_stat_q & irq_en_q);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_len_cap: assert property (@(posedge CLK) disable iff (!RST_N) // RULE5
      TX_REQ |-> TX_FRAME.len <= cmo_pkg::LEN_CAP)
      else $error("transmit length above eight");

   chk_std_format: assert property (@(posedge CLK) disable iff (!RST_N) // RULE4
      TX_REQ && !TX_FRAME.ext |-> TX_FRAME.id[28:11] == 18'h00000 && !TX_FRAME.resv1)
      else $error("standard frame carries extended bits");

   chk_cfg_arms: assert property (@(posedge CLK) disable iff (!RST_N) // RULE2
      wr_ok && page_ok && addr_q == cmo_pkg::OFF_CTRL |=> armed_q[$past(sel)])
      else $error("config write did not set enable bit");

   chk_done_disarm: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
      TX_DONE && tx_req_q && !wr_ok |=> !armed_q[$past(tx_obj_q)])
      else $error("object still enabled after completion");

   chk_done_keeps_cfg: assert property (@(posedge CLK) disable iff (!RST_N) // RULE1
      TX_DONE && tx_req_q && !wr_ok |=> cfg_q[$past(tx_obj_q)] == cmo_pkg::CFG_TX)
      else $error("configuration changed by completion");

   chk_reply_clears: assert property (@(posedge CLK) disable iff (!RST_N) // RULE10
      auto_reply && !wr_ok |=> !tag_q[$past(hit_obj)][cmo_pkg::TAG_REMOTE]
         && cfg_q[$past(hit_obj)] == cmo_pkg::CFG_TX)
      else $error("automatic reply kept remote bit");

   chk_reply_gate: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
      RX_VALID && hit && !rply_q[hit_obj] && !wr_ok |=> cfg_q[$past(hit_obj)] != cmo_pkg::CFG_TX)
      else $error("reply sent while not valid");

   chk_len_warn: assert property (@(posedge CLK) disable iff (!RST_N) // RULE6
      RX_VALID && hit && RX_FRAME.len != len_q[hit_obj] && !wr_ok |=> lenw_q[$past(hit_obj)]
         && len_q[$past(hit_obj)] == $past(RX_FRAME.len) && irq_stat_q[cmo_pkg::IRQ_LENW])
      else $error("length mismatch not flagged");

   chk_page_range: assert property (@(posedge CLK) disable iff (!RST_N) // RULE17
      wr_ok && !page_ok |=> armed_q == $past(armed_q) || $past(TX_DONE || RX_VALID))
      else $error("out of range page changed an object");

   chk_rx_done: assert property (@(posedge CLK) disable iff (!RST_N) // RULE18
      RX_VALID && hit && !auto_reply |=> rxok_q[$past(hit_obj)] && !armed_q[$past(hit_obj)]
         || $past(wr_ok))
      else $error("accepted frame not recorded");

endmodule

// ==== cmo_engine.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// far-side protocol engine model
// ------------------------------------------------------------
module cmo_engine (
   input  wire logic           CLK,
   input  wire logic           RST_N,
   input  wire logic           TX_REQ,
   output logic                TX_DONE,
   output logic                RX_VALID,
   output cmo_pkg::cmo_frame_t RX_FRAME
);
   int cnt;
   initial begin
      RX_VALID = 1'b0;
      RX_FRAME = '0;
   end
   // slow answer on purpose so software can look at the request in flight
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cnt     <= 0;
         TX_DONE <= 1'b0;
      end else begin
         TX_DONE <= TX_REQ && !TX_DONE && cnt == 8;
         cnt     <= (TX_REQ && !TX_DONE && cnt < 8) ? cnt + 1 : 0;
      end
   end
   // frame lines carry inverted junk between frames, never the last value
   task automatic send(input cmo_pkg::cmo_frame_t f);
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_FRAME <= f;
      @(posedge CLK);
      RX_VALID <= 1'b0;
      RX_FRAME <= ~f;
   endtask
endmodule

// ==== cmo_descriptor_test.sv ====
`timescale 1ns/100ps
module cmo_descriptor_test;
   logic                CLK = 1'b0;
   logic                RST_N = 1'b0;
   logic                HSEL = 1'b0;
   logic                HWRITE = 1'b0;
   logic [1:0]          HTRANS = 2'h0;
   logic [31:0]         HADDR = 32'h0;
   logic [31:0]         HWDATA = 32'h0;
   logic [15:0]         STAMP_NOW = 16'hBEEF;
   logic                HREADYOUT, HRESP, TX_REQ, TX_DONE, RX_VALID, IRQ;
   logic [31:0]         HRDATA, rd;
   cmo_pkg::cmo_frame_t RX_FRAME, TX_FRAME;
   int                  n_errors = 0;
   int                  checked = 0;
   always #20 CLK = ~CLK;
   cmo_descriptor cmo_descriptor_inst (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .RX_VALID(RX_VALID),
      .RX_FRAME(RX_FRAME), .STAMP_NOW(STAMP_NOW), .TX_REQ(TX_REQ), .TX_FRAME(TX_FRAME),
      .TX_DONE(TX_DONE), .IRQ(IRQ));
   cmo_engine cmo_engine_inst (.CLK(CLK), .RST_N(RST_N), .TX_REQ(TX_REQ), .TX_DONE(TX_DONE),
      .RX_VALID(RX_VALID), .RX_FRAME(RX_FRAME));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic tmo(input int n);
      if (n > 20) begin
         n_errors++;
         final_report;
      end
   endtask
   task automatic rdy;
      int n;
      n = 0;
      while (HREADYOUT !== 1'b1) begin
         @(posedge CLK);
         n++;
         tmo(n);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge CLK);
      HSEL   <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR  <= {24'h0, a};
      @(posedge CLK);
      rdy;
      HSEL   <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      @(posedge CLK);
      rdy;
      rd = HRDATA;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d});
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd & {24'h0, m}, {24'h0, e});
   endtask
   // tag and mask bytes go byte4 first, lowest bits first
   task automatic w4(input logic [7:0] base, input logic [31:0] v);
      for (int i = 0; i < 4; i++) begin
         wr(base + 8'(4 * i), v[8 * i +: 8]);
      end
   endtask
   task automatic wt(input logic v);
      int n;
      n = 0;
      @(negedge CLK);
      while (TX_REQ !== v) begin
         @(negedge CLK);
         n++;
         tmo(n);
      end
   endtask
   function automatic cmo_pkg::cmo_frame_t mk(input logic [28:0] id, input logic [3:0] f,
                                             input logic [3:0] len);
      return {id, f, len};
   endfunction
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rc(cmo_pkg::OFF_PAGE, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_ENABLE, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_IRQ_STAT, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_IRQ_EN, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_IRQ_CLR, 8'hFF, 8'h00);
      rc(8'h80, 8'hFF, 8'h00);
      wr(cmo_pkg::OFF_PAGE, 8'h60);
      wr(cmo_pkg::OFF_CTRL, 8'h40);
      rc(cmo_pkg::OFF_CTRL, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_ENABLE, 8'hFF, 8'h00);
      chk({31'h0, HRESP}, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_rx;
      wr(cmo_pkg::OFF_PAGE, 8'h00);
      w4(cmo_pkg::OFF_TAG4, 32'h54A0_0000);
      w4(cmo_pkg::OFF_MASK4, 32'hFEE0_0005);
      wr(cmo_pkg::OFF_CTRL, 8'h82);
      rc(cmo_pkg::OFF_OBJ_STAT, 8'hFF, 8'h00);
      cmo_engine_inst.send(mk(29'h2A5, 4'h8, 4'h5));
      cmo_engine_inst.send(mk(29'h6A5, 4'h0, 4'h5));
      rc(cmo_pkg::OFF_OBJ_STAT, 8'hFF, 8'h00);
      rc(cmo_pkg::OFF_ENABLE, 8'h01, 8'h01);
      cmo_engine_inst.send(mk(29'h2AD, 4'h3, 4'h5));
      wr(cmo_pkg::OFF_STAMP_LO, 8'h00);
      rc(cmo_pkg::OFF_OBJ_STAT, 8'hE0, 8'hA0);
      rc(cmo_pkg::OFF_CTRL, 8'hDF, 8'h85);
      rc(cmo_pkg::OFF_TAG1, 8'hFF, 8'h55);
      rc(cmo_pkg::OFF_TAG2, 8'hE0, 8'hA0);
      rc(cmo_pkg::OFF_TAG4, 8'h05, 8'h01);
      rc(cmo_pkg::OFF_STAMP_LO, 8'hFF, 8'hEF);
      rc(cmo_pkg::OFF_STAMP_HI, 8'hFF, 8'hBE);
      rc(cmo_pkg::OFF_ENABLE, 8'h01, 8'h00);
      rc(cmo_pkg::OFF_IRQ_STAT, 8'h06, 8'h06);
      $display("test receive done");
   endtask
   task automatic t_tx;
      wr(cmo_pkg::OFF_PAGE, 8'h10);
      w4(cmo_pkg::OFF_TAG4, 32'h091A_2B3A);
      wr(cmo_pkg::OFF_IRQ_EN, 8'h07);
      wr(cmo_pkg::OFF_CTRL, 8'h5F);
      wt(1'b1);
      chk({3'h0, TX_FRAME.id}, 32'h0123_4567);
      chk({28'h0, TX_FRAME.len}, 32'h8);
      chk({28'h0, TX_FRAME[7:4]}, 32'h6);
      rc(cmo_pkg::OFF_ENABLE, 8'h02, 8'h02);
      wt(1'b0);
      wr(cmo_pkg::OFF_OBJ_STAT, 8'h00);
      rc(cmo_pkg::OFF_OBJ_STAT, 8'h60, 8'h40);
      rc(cmo_pkg::OFF_CTRL, 8'hF0, 8'h50);
      rc(cmo_pkg::OFF_ENABLE, 8'h02, 8'h00);
      chk({31'h0, TX_REQ}, 32'h0);
      chk({31'h0, IRQ}, 32'h1);
      wr(cmo_pkg::OFF_IRQ_EN, 8'h00);
      @(negedge CLK);
      chk({31'h0, IRQ}, 32'h0);
      wr(cmo_pkg::OFF_IRQ_EN, 8'h07);
      wr(cmo_pkg::OFF_IRQ_CLR, 8'h07);
      rc(cmo_pkg::OFF_IRQ_STAT, 8'h07, 8'h00);
      chk({31'h0, IRQ}, 32'h0);
      $display("test transmit done");
   endtask
   task automatic t_reply;
      wr(cmo_pkg::OFF_PAGE, 8'h20);
      w4(cmo_pkg::OFF_TAG4, 32'h2460_0000);
      w4(cmo_pkg::OFF_MASK4, 32'hFFE0_0001);
      wr(cmo_pkg::OFF_CTRL, 8'hA0);
      cmo_engine_inst.send(mk(29'h123, 4'h8, 4'h0));
      wt(1'b1);
      chk({3'h0, TX_FRAME.id}, 32'h123);
      chk({31'h0, TX_FRAME.remote}, 32'h0);
      wt(1'b0);
      rc(cmo_pkg::OFF_OBJ_STAT, 8'h60, 8'h40);
      wr(cmo_pkg::OFF_PAGE, 8'h30);
      w4(cmo_pkg::OFF_MASK4, 32'h0000_0001);
      wr(cmo_pkg::OFF_CTRL, 8'hD1);
      cmo_engine_inst.send(mk(29'h1ABCDEF5, 4'h4, 4'h1));
      rc(cmo_pkg::OFF_TAG1, 8'hFF, 8'hD5);
      rc(cmo_pkg::OFF_TAG4, 8'hFF, 8'hA8);
      rc(cmo_pkg::OFF_CTRL, 8'hDF, 8'hD1);
      rc(cmo_pkg::OFF_OBJ_STAT, 8'hE0, 8'h20);
      $display("test reply done");
   endtask
   initial begin
      repeat (6) @(posedge CLK);
      RST_N <= 1'b1;
      t_reset;
      t_rx;
      t_tx;
      t_reply;
      final_report;
   end
endmodule
